// ==== rtl/dcp_dev.sv ====
// device end: SPI/I2C slave giving access to the byte register map
`timescale 1ns/10ps
`default_nettype none
module dcp_dev (
	input wire logic ref_clk_i, // system clock
	input wire logic srst_i, // sync reset, active high
	dcp_if.dev lnk, // link pins
	input wire logic addr_strap_bit1_i, // address strap pin
	input wire logic general_output_two_i, // pin level, strap
	input wire logic general_output_two_val_i, // level to drive on the pin
	output logic general_output_two_o, // drive value
	output logic general_output_two_oe_o, // drive enable, off in reset
	input wire logic [6:0] err_event_i, // error events, one per bit
	input wire logic [7:0] reg_rdata_i, // map data at reg_ptr_o, combinational
	output logic [6:0] reg_ptr_o, // current register pointer
	output logic reg_wr_o, // write pulse
	output logic reg_rd_o, // read pulse, byte at acc_addr_o taken
	output logic [6:0] acc_addr_o, // address of last write or read
	output logic [7:0] reg_wdata_o, // write data
	output logic [6:0] err_status_o, // sticky error bits
	output logic spi_mode_o // 1 once SPI chosen
);
	import dcp_pkg::*;
	logic [PIN_W-1:0] raw, s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;
	logic [PIN_W-1:0] f_reg, f_next, stable, rise, fall;
	logic spi_reg, spi_next;
	logic [2:0] strap_reg, strap_next;
	dcp_phase_t ph_reg, ph_next;
	dcp_i2c_t ist_reg, ist_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
	logic [6:0] ptr_reg, ptr_next, acc_reg, acc_next;
	logic [7:0] wd_reg, wd_next;
	logic wr_reg, wr_next, rd_reg, rd_next;
	logic sdo_reg, sdo_next, sdoe_reg, sdoe_next, sdae_reg, sdae_next;
	logic [ERR_W-1:0] err_reg, err_next;
	logic g2_reg, g2_next, g2oe_reg, g2oe_next;
	logic [7:0] rd_byte, byte_in;
	logic fetch, store, start_c, stop_c;

	assign raw = {general_output_two_i, addr_strap_bit1_i, lnk.sda, lnk.host_serial_in,
		lnk.addr0_or_select_pin, lnk.host_bit_clock};

	always_comb begin
		s1_next = raw;
		s2_next = s1_reg;
		s3_next = s2_reg;
		// a pin counts as changed once the last two stages agree
		stable = ~(s2_reg ^ s3_reg);
		f_next = srst_i ? s3_reg : ((s3_reg & stable) | (f_reg & ~stable));
		rise = f_next & ~f_reg;
		fall = ~f_next & f_reg;
		start_c = fall[PIN_SDA] & f_next[PIN_SCL];
		stop_c = rise[PIN_SDA] & f_next[PIN_SCL];
		rd_byte = (ptr_reg == ERR_REG_ADDR) ? {1'b0, err_reg} : reg_rdata_i;
		byte_in = {sh_reg[6:0], f_reg[PIN_SDI]};
		fetch = 1'b0;
		store = 1'b0;
		spi_next = spi_reg;
		strap_next = strap_reg;
		ph_next = ph_reg;
		ist_next = ist_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		acc_next = acc_reg;
		wd_next = wd_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		sdo_next = sdo_reg;
		sdoe_next = sdoe_reg;
		sdae_next = sdae_reg;
		if (!spi_reg && fall[PIN_CS]) begin
			spi_next = 1'b1; // RULE1
		end
		if (spi_reg) begin
			sdae_next = 1'b0;
			if (f_reg[PIN_CS]) begin
				// deselected: restart header, release output
				cnt_next = 4'h0;
				ph_next = DCP_PH_ADDR; // RULE3
				sdoe_next = 1'b0;
			end else if (rise[PIN_SCL] && ph_reg != DCP_PH_READ) begin
				sh_next = byte_in; // RULE2
				cnt_next = cnt_reg + 4'h1;
				sdoe_next = 1'b0; // RULE7
				if (cnt_reg == 4'h7) begin
					cnt_next = 4'h0;
					case (ph_reg)
						DCP_PH_ADDR: begin
							if (byte_in[7:1] == SPI_DEV_ADDR) begin // RULE3
								ph_next = byte_in[0] ? DCP_PH_READ : DCP_PH_PTR; // RULE4
							end else begin
								ph_next = DCP_PH_IGNORE;
							end
						end
						DCP_PH_PTR: begin
							ptr_next = byte_in[6:0]; // RULE5
							ph_next = DCP_PH_DATA;
						end
						DCP_PH_DATA: store = 1'b1; // RULE6
						default: ;
					endcase
				end
			end else if (fall[PIN_SCL] && ph_reg == DCP_PH_READ) begin
				sdoe_next = 1'b1; // RULE9
				if (cnt_reg == 4'h0) begin
					fetch = 1'b1;
					sdo_next = rd_byte[7]; // RULE9
					tx_next = {rd_byte[6:0], 1'b0};
				end else begin
					sdo_next = tx_reg[7]; // RULE2
					tx_next = {tx_reg[6:0], 1'b0};
				end
				cnt_next = (cnt_reg == 4'h7) ? 4'h0 : cnt_reg + 4'h1;
			end
		end else if (start_c) begin
			ist_next = DCP_I2C_RX;
			ph_next = DCP_PH_ADDR; // RULE13
			cnt_next = 4'h0;
			sdae_next = 1'b0;
		end else if (stop_c) begin
			ist_next = DCP_I2C_IDLE;
			sdae_next = 1'b0;
		end else begin
			case (ist_reg)
				DCP_I2C_RX: begin
					if (rise[PIN_SCL]) begin
						sh_next = {sh_reg[6:0], f_reg[PIN_SDA]};
						cnt_next = cnt_reg + 4'h1;
					end else if (fall[PIN_SCL] && cnt_reg == 4'h8) begin
						cnt_next = 4'h0;
						ist_next = DCP_I2C_ACK;
						sdae_next = 1'b1; // RULE17
						case (ph_reg)
							DCP_PH_ADDR: begin
								if (sh_reg[7:1] == {I2C_ADDR_HI, strap_reg}) begin // RULE12
									ph_next = sh_reg[0] ? DCP_PH_READ : DCP_PH_PTR; // RULE13
								end else begin
									// no ack; wait for the next start
									ist_next = DCP_I2C_IDLE; // RULE21
									sdae_next = 1'b0; // RULE21
								end
							end
							DCP_PH_PTR: begin
								ptr_next = sh_reg[6:0]; // RULE15
								ph_next = DCP_PH_DATA;
							end
							default: store = 1'b1;
						endcase
					end
				end
				DCP_I2C_ACK, DCP_I2C_HACK: begin
					if (rise[PIN_SCL] && ist_reg == DCP_I2C_HACK && f_reg[PIN_SDA]) begin
						ist_next = DCP_I2C_IDLE; // RULE17
					end else if (fall[PIN_SCL]) begin
						if (ph_reg == DCP_PH_READ) begin
							fetch = 1'b1; // RULE16
							sdae_next = ~rd_byte[7]; // RULE14
							tx_next = {rd_byte[6:0], 1'b0};
							cnt_next = 4'h1;
							ist_next = DCP_I2C_TX;
						end else begin
							sdae_next = 1'b0;
							ist_next = DCP_I2C_RX;
						end
					end
				end
				DCP_I2C_TX: begin
					if (fall[PIN_SCL]) begin
						if (cnt_reg == 4'h8) begin
							sdae_next = 1'b0;
							cnt_next = 4'h0;
							ist_next = DCP_I2C_HACK;
						end else begin
							sdae_next = ~tx_reg[7]; // RULE14
							tx_next = {tx_reg[6:0], 1'b0};
							cnt_next = cnt_reg + 4'h1;
						end
					end
				end
				default: ;
			endcase
		end
		if (store) begin
			wr_next = 1'b1; // RULE6
			acc_next = ptr_reg;
			wd_next = spi_reg ? byte_in : sh_reg;
			ptr_next = ptr_reg + 7'h1; // RULE10
		end
		if (fetch) begin
			rd_next = 1'b1;
			acc_next = ptr_reg;
			ptr_next = ptr_reg + 7'h1; // RULE10 RULE16
		end
		// a new error in the clearing cycle survives the read
		err_next = ((fetch && ptr_reg == ERR_REG_ADDR) ? '0 : err_reg) | err_event_i; // RULE20
		g2_next = general_output_two_val_i;
		g2oe_next = 1'b1;
		if (srst_i) begin
			// straps sensed while reset is held, general_output_two left undriven
			strap_next = {s3_reg[PIN_GP2], s3_reg[PIN_STRAP1], s3_reg[PIN_CS]}; // RULE11
			g2oe_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		s1_reg <= s1_next;
		s2_reg <= s2_next;
		s3_reg <= s3_next;
		f_reg <= f_next;
		strap_reg <= strap_next;
		g2oe_reg <= g2oe_next;
		if (srst_i) begin
			spi_reg <= 1'b0;
			ph_reg <= DCP_PH_ADDR;
			ist_reg <= DCP_I2C_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h0;
			tx_reg <= 8'h0;
			ptr_reg <= PTR_RESET; // RULE22
			acc_reg <= 7'h0;
			wd_reg <= 8'h0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			sdo_reg <= 1'b0;
			sdoe_reg <= 1'b0;
			sdae_reg <= 1'b0;
			err_reg <= '0;
			g2_reg <= 1'b0;
		end else begin
			spi_reg <= spi_next;
			ph_reg <= ph_next;
			ist_reg <= ist_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			acc_reg <= acc_next;
			wd_reg <= wd_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			sdo_reg <= sdo_next;
			sdoe_reg <= sdoe_next;
			sdae_reg <= sdae_next;
			err_reg <= err_next;
			g2_reg <= g2_next;
		end
	end

	assign lnk.dev_sdo_o = sdo_reg;
	assign lnk.dev_sdo_oe = sdoe_reg;
	assign lnk.sda_dev_o = 1'b0;
	assign lnk.sda_dev_oe = sdae_reg;
	assign general_output_two_o = g2_reg;
	assign general_output_two_oe_o = g2oe_reg;
	assign reg_ptr_o = ptr_reg;
	assign reg_wr_o = wr_reg;
	assign reg_rd_o = rd_reg;
	assign acc_addr_o = acc_reg;
	assign reg_wdata_o = wd_reg;
	assign err_status_o = err_reg;
	assign spi_mode_o = spi_reg;
endmodule
`default_nettype wire

// ==== rtl/dcp_pkg.sv ====
// shared constants and types of the dual-mode control port
// How it works
// RULE1 - select pin falling after reset picks SPI
// RULE2 - SPI: sample on rising, drive on falling
// RULE3 - SPI: select low, device address 0010000
// RULE4 - SPI: eighth bit low write, high read
// RULE5 - SPI write: next byte loads 7-bit pointer
// RULE6 - SPI write: following byte stored at pointer
// RULE7 - SPI output released during whole write
// RULE8 - host sets pointer by short write first
// RULE9 - SPI read: drive MSB from next falling edge
// RULE10 - SPI: pointer increments after each data byte
// RULE11 - I2C low address bits strapped during reset
// RULE12 - I2C address upper 0010, lower strapped bits
// RULE13 - I2C first byte: address plus direction bit
// RULE14 - I2C data changes only while clock low
// RULE15 - I2C write: byte after address loads pointer
// RULE16 - I2C read: pointer register out, auto-increment
// RULE17 - receiver of each byte drives acknowledge; the host leaves its read byte unacknowledged
// RULE18 - I2C read preceded by pointer write, stop
// RULE19 - host keeps lines static when idle
// RULE20 - error bits sticky until read by host
// RULE21 - unmatched I2C address unacked, ignored till start
// RULE22 - pointer cleared to zero during reset
package dcp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 160;
	localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam logic [6:0] SPI_DEV_ADDR = 7'h10;
	localparam logic [3:0] I2C_ADDR_HI = 4'h2;
	localparam logic [6:0] ERR_REG_ADDR = 7'h0c;
	localparam logic [6:0] PTR_RESET = 7'h00;
	localparam int ERR_W = 7;
	localparam int PIN_W = 6;
	localparam int PIN_SCL = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDI = 2;
	localparam int PIN_SDA = 3;
	localparam int PIN_STRAP1 = 4;
	localparam int PIN_GP2 = 5;
	typedef enum logic [1:0] {DCP_OP_WRITE, DCP_OP_SETPTR, DCP_OP_READ} dcp_op_t;
	typedef enum {DCP_PH_ADDR, DCP_PH_PTR, DCP_PH_DATA, DCP_PH_READ, DCP_PH_IGNORE} dcp_phase_t;
	typedef enum {DCP_I2C_IDLE, DCP_I2C_RX, DCP_I2C_ACK, DCP_I2C_TX, DCP_I2C_HACK} dcp_i2c_t;
	typedef enum {DCP_H_IDLE, DCP_H_START, DCP_H_BITS, DCP_H_STOP} dcp_host_t;
endpackage

// ==== rtl/dcp_if.sv ====
// link wires between host and device, with open-drain and tri-state resolution
`timescale 1ns/10ps
`default_nettype none
interface dcp_if;
	logic host_bit_clock;
	logic addr0_or_select_pin;
	logic host_serial_in;
	logic dev_sdo_o;
	logic dev_sdo_oe;
	logic host_serial_out;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda;
	// undriven serial output reads as pulled high
	assign host_serial_out = dev_sdo_oe ? dev_sdo_o : 1'b1;
	assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
	modport dev (input host_bit_clock, addr0_or_select_pin, host_serial_in, sda,
		output dev_sdo_o, dev_sdo_oe, sda_dev_o, sda_dev_oe);
	modport host (input host_serial_out, sda,
		output host_bit_clock, addr0_or_select_pin, host_serial_in, sda_host_o, sda_host_oe);
endinterface
`default_nettype wire

// ==== rtl/dcp_host.sv ====
// host end: drives SPI or I2C transfers from simple commands
`timescale 1ns/10ps
`default_nettype none
module dcp_host (
	input wire logic ref_clk_i, // system clock
	input wire logic srst_i, // sync reset, active high
	dcp_if.host lnk, // link pins
	input wire logic i2c_mode_i, // 1: I2C, 0: SPI; keep static
	input wire logic addr_strap_bit0_i, // level held on select pin in I2C
	input wire logic cmd_valid_i, // command request
	input wire dcp_pkg::dcp_op_t cmd_op_i, // write, set pointer or read
	input wire logic [6:0] cmd_dev_addr_i, // device address
	input wire logic [6:0] cmd_ptr_i, // register pointer
	input wire logic [7:0] cmd_data_i, // write data
	output logic cmd_ready_o, // idle, command taken when valid
	output logic done_o, // one-cycle pulse at transfer end
	output logic [7:0] rdata_o // last byte read
);
	import dcp_pkg::*;
	logic [1:0] s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next, f_reg, f_next;
	logic [1:0] stable;
	dcp_host_t st_reg, st_next;
	logic [2:0] qc_reg, qc_next;
	logic [1:0] q_reg, q_next;
	logic [26:0] bits_reg, bits_next, rel_reg, rel_next;
	logic [4:0] n_reg, n_next;
	logic [8:0] rx_reg, rx_next;
	logic i2c_reg, i2c_next, rd_reg, rd_next, clk_reg, clk_next, cs_reg, cs_next;
	logic mosi_reg, mosi_next, oe_reg, oe_next, pin_reg, pin_next;
	logic ready_reg, ready_next, done_reg, done_next;
	logic [7:0] rdata_reg, rdata_next;
	logic tick, in_bit;
	logic [7:0] p8;

	always_comb begin
		s1_next = {lnk.sda, lnk.host_serial_out};
		s2_next = s1_reg;
		s3_next = s2_reg;
		stable = ~(s2_reg ^ s3_reg);
		f_next = (s3_reg & stable) | (f_reg & ~stable);
		tick = (qc_reg == 3'(QTR_CYC - 1));
		in_bit = i2c_reg ? f_reg[1] : f_reg[0];
		p8 = {1'b0, cmd_ptr_i};
		st_next = st_reg;
		qc_next = tick ? 3'h0 : qc_reg + 3'h1;
		q_next = q_reg;
		bits_next = bits_reg;
		rel_next = rel_reg;
		n_next = n_reg;
		rx_next = rx_reg;
		i2c_next = i2c_reg;
		rd_next = rd_reg;
		clk_next = clk_reg;
		cs_next = cs_reg;
		mosi_next = mosi_reg;
		oe_next = oe_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		case (st_reg)
			DCP_H_IDLE: begin
				// lines stay parked while nothing is asked
				clk_next = 1'b1; // RULE19
				cs_next = 1'b1;
				oe_next = 1'b0;
				qc_next = 3'h0;
				q_next = 2'h0;
				if (cmd_valid_i) begin
					i2c_next = i2c_mode_i;
					rd_next = (cmd_op_i == DCP_OP_READ);
					st_next = DCP_H_START;
					if (i2c_mode_i) begin
						case (cmd_op_i)
							DCP_OP_READ: begin // RULE13 RULE18
								bits_next = {cmd_dev_addr_i, 1'b1, 1'b1, 8'hff, 1'b1, 9'h0};
								rel_next = {8'h0, 1'b1, 8'hff, 1'b0, 9'h0};
								n_next = 5'd18;
							end
							default: begin // RULE13 RULE17
								bits_next = {cmd_dev_addr_i, 1'b0, 1'b1, p8, 1'b1, cmd_data_i, 1'b1};
								rel_next = {8'h0, 1'b1, 8'h0, 1'b1, 8'h0, 1'b1};
								n_next = (cmd_op_i == DCP_OP_WRITE) ? 5'd27 : 5'd18;
							end
						endcase
					end else begin
						rel_next = (cmd_op_i == DCP_OP_READ) ? {8'h0, 8'hff, 11'h0} : 27'h0;
						bits_next = {cmd_dev_addr_i, cmd_op_i == DCP_OP_READ, p8, cmd_data_i, 3'h0}; // RULE3 RULE4 RULE5
						n_next = (cmd_op_i == DCP_OP_WRITE) ? 5'd24 : 5'd16; // RULE8
					end
				end
			end
			DCP_H_START: begin
				if (tick) begin
					q_next = q_reg + 2'h1;
					if (q_reg == 2'h1) begin
						if (i2c_reg) begin
							oe_next = 1'b1;
						end else begin
							cs_next = 1'b0;
						end
					end
					if (q_reg == 2'h3) begin
						clk_next = 1'b0;
						mosi_next = bits_reg[26];
						oe_next = i2c_reg & ~rel_reg[26] & ~bits_reg[26];
						st_next = DCP_H_BITS;
					end
				end
			end
			DCP_H_BITS: begin
				if (tick) begin
					q_next = q_reg + 2'h1;
					case (q_reg)
						// two quarters low, so the far end's late reply settles first
						2'h1: clk_next = 1'b1; // RULE14
						2'h2: rx_next = {rx_reg[7:0], in_bit}; // RULE2
						2'h3: begin
							// data moves only with the clock low
							clk_next = 1'b0; // RULE14
							bits_next = {bits_reg[25:0], 1'b0};
							rel_next = {rel_reg[25:0], 1'b0};
							mosi_next = bits_reg[25];
							oe_next = i2c_reg & ~rel_reg[25] & ~bits_reg[25];
							n_next = n_reg - 5'd1;
							if (n_reg == 5'd1) begin
								// spi ends high: a trailing fall would fetch one byte too many
								clk_next = ~i2c_reg; // RULE10
								oe_next = 1'b0;
								st_next = DCP_H_STOP;
							end
						end
						default: ;
					endcase
				end
			end
			DCP_H_STOP: begin
				if (tick) begin
					q_next = q_reg + 2'h1;
					case (q_reg)
						2'h0: begin
							if (i2c_reg) begin
								oe_next = 1'b1;
							end else begin
								clk_next = 1'b1;
							end
						end
						2'h1: begin
							if (i2c_reg) begin
								clk_next = 1'b1;
							end else begin
								cs_next = 1'b1;
							end
						end
						2'h2: oe_next = 1'b0;
						default: begin
							done_next = 1'b1;
							if (rd_reg) begin
								rdata_next = i2c_reg ? rx_reg[8:1] : rx_reg[7:0];
							end
							st_next = DCP_H_IDLE;
						end
					endcase
				end
			end
			default: st_next = DCP_H_IDLE;
		endcase
		ready_next = (st_next == DCP_H_IDLE);
		pin_next = i2c_mode_i ? addr_strap_bit0_i : cs_next;
	end

	always_ff @(posedge ref_clk_i) begin
		s1_reg <= s1_next;
		s2_reg <= s2_next;
		s3_reg <= s3_next;
		if (srst_i) begin
			f_reg <= 2'h3;
			st_reg <= DCP_H_IDLE;
			qc_reg <= 3'h0;
			q_reg <= 2'h0;
			bits_reg <= 27'h0;
			rel_reg <= 27'h0;
			n_reg <= 5'h0;
			rx_reg <= 9'h0;
			i2c_reg <= 1'b0;
			rd_reg <= 1'b0;
			clk_reg <= 1'b1;
			cs_reg <= 1'b1;
			mosi_reg <= 1'b1;
			oe_reg <= 1'b0;
			// strap level from reset on, else a low strap falls and picks spi
			pin_reg <= i2c_mode_i ? addr_strap_bit0_i : 1'b1; // RULE11
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= 8'h0;
		end else begin
			f_reg <= f_next;
			st_reg <= st_next;
			qc_reg <= qc_next;
			q_reg <= q_next;
			bits_reg <= bits_next;
			rel_reg <= rel_next;
			n_reg <= n_next;
			rx_reg <= rx_next;
			i2c_reg <= i2c_next;
			rd_reg <= rd_next;
			clk_reg <= clk_next;
			cs_reg <= cs_next;
			mosi_reg <= mosi_next;
			oe_reg <= oe_next;
			pin_reg <= pin_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	assign lnk.host_bit_clock = clk_reg;
	assign lnk.addr0_or_select_pin = pin_reg;
	assign lnk.host_serial_in = mosi_reg;
	assign lnk.sda_host_o = 1'b0;
	assign lnk.sda_host_oe = oe_reg;
	assign cmd_ready_o = ready_reg;
	assign done_o = done_reg;
	assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// ==== verif/dcp_link_props.sv ====
// concurrent checks on the link wires between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module dcp_link_props
	import dcp_pkg::*;
#(
	parameter logic [2:0] I2C_LOW = 3'h0 // strapped low address bits
) (
	input wire logic ref_clk_i, // system clock
	input wire logic srst_i, // sync reset, active high
	input wire logic host_bit_clock, // link clock
	input wire logic addr0_or_select_pin, // select or strap
	input wire logic host_serial_in, // spi data to device
	input wire logic dev_sdo_o, // spi data from device
	input wire logic dev_sdo_oe, // spi output enable
	input wire logic sda, // resolved i2c data
	input wire logic sda_dev_oe // device pulls sda low
);
	logic clk_q_reg, clk_q_next, sda_q_reg, sda_q_next, rise, start;
	logic [3:0] scnt_reg, scnt_next, icnt_reg, icnt_next;
	logic [7:0] sbits_reg, sbits_next, ibits_reg, ibits_next;
	assign rise = host_bit_clock & ~clk_q_reg;
	assign start = host_bit_clock & clk_q_reg & sda_q_reg & ~sda;
	always_comb begin
		clk_q_next = host_bit_clock;
		sda_q_next = sda;
		scnt_next = scnt_reg;
		sbits_next = sbits_reg;
		icnt_next = icnt_reg;
		ibits_next = ibits_reg;
		if (addr0_or_select_pin) begin
			scnt_next = 4'h0;
		end else if (rise && scnt_reg < 4'hf) begin
			scnt_next = scnt_reg + 4'h1;
			if (scnt_reg < 4'h8) begin
				sbits_next = {sbits_reg[6:0], host_serial_in};
			end
		end
		if (start) begin
			icnt_next = 4'h0;
		end else if (rise && icnt_reg < 4'hf) begin
			icnt_next = icnt_reg + 4'h1;
			if (icnt_reg < 4'h8) begin
				ibits_next = {ibits_reg[6:0], sda};
			end
		end
	end
	// count parked at f outside a frame, so no ack slot is seen before a start
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			clk_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			scnt_reg <= 4'h0;
			icnt_reg <= 4'hf;
			sbits_reg <= 8'h00;
			ibits_reg <= 8'h00;
		end else begin
			clk_q_reg <= clk_q_next;
			sda_q_reg <= sda_q_next;
			scnt_reg <= scnt_next;
			icnt_reg <= icnt_next;
			sbits_reg <= sbits_next;
			ibits_reg <= ibits_next;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_read_hdr;
		$fell(host_bit_clock) && !addr0_or_select_pin && scnt_reg == 4'h8
			&& sbits_reg == {SPI_DEV_ADDR, 1'b1};
	endsequence
	sequence s_ack_slot;
		rise && icnt_reg == 4'h8;
	endsequence
	// device sees edges a few cycles late, so skip two cycles after the rise
	sequence s_hold_bit;
		##2 ($stable(dev_sdo_o) [*6]);
	endsequence
	a_sdo_off_desel: assert property (addr0_or_select_pin [*8] |-> !dev_sdo_oe)
		else $error("spi output driven while deselected");
	a_sdo_write_off: assert property (!addr0_or_select_pin && scnt_reg >= 4'h8 && !sbits_reg[0] |-> !dev_sdo_oe)
		else $error("spi output driven during a write");
	a_sdo_addr_off: assert property (!addr0_or_select_pin && scnt_reg >= 4'h8
		&& sbits_reg[7:1] != SPI_DEV_ADDR |-> !dev_sdo_oe)
		else $error("spi output driven for a foreign address");
	a_sdo_read_on: assert property (s_read_hdr |-> ##[1:6] dev_sdo_oe)
		else $error("spi output not driven after read header");
	a_sdo_hold_bit: assert property ($rose(host_bit_clock) && dev_sdo_oe |-> s_hold_bit)
		else $error("spi output changed while clock high");
	a_sda_low_clk: assert property ($changed(sda_dev_oe) |-> !$past(host_bit_clock))
		else $error("device changed sda while clock high");
	a_i2c_ack_hit: assert property (s_ack_slot ##0 ibits_reg[7:1] == {I2C_ADDR_HI, I2C_LOW}
		|-> ##[0:7] sda_dev_oe)
		else $error("matching i2c address not acknowledged");
	a_i2c_nack_miss: assert property (s_ack_slot ##0 ibits_reg[7:1] != {I2C_ADDR_HI, I2C_LOW}
		|-> (!sda_dev_oe) [*8])
		else $error("foreign i2c address acknowledged");
endmodule
`default_nettype wire

// ==== verif/test_dual_mode_control_port_slave.sv ====
// self-checking bench joining the host and device ends over one link
`timescale 1ns/10ps
`default_nettype none
module test_dual_mode_control_port_slave;
	import dcp_pkg::*;
	localparam logic [2:0] I2C_LOW = 3'h5;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic i2c_mode = 1'b0;
	logic cmd_valid = 1'b0;
	dcp_op_t cmd_op = DCP_OP_WRITE;
	logic [6:0] cmd_dev = 7'h00;
	logic [6:0] cmd_ptr = 7'h00;
	logic [7:0] cmd_data = 8'h00;
	logic [6:0] err_event = 7'h00;
	logic cmd_ready, done, reg_wr, reg_rd, gen_out2, gen_out2_oe, spi_mode;
	logic [7:0] rdata, reg_rdata, reg_wdata;
	logic [6:0] reg_ptr, acc_addr, err_status;
	int err_count = 0;
	int num_checks = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	int cycles = 0;
	dcp_if lnk();
	always #(CLK_PERIOD_NS / 2) clk = ~clk;
	assign reg_rdata = {1'b1, ~reg_ptr};
	// straps give low address bits 2 1 0 = 1 0 1
	dcp_host i_dcp_host (.ref_clk_i(clk), .srst_i(srst), .lnk(lnk), .i2c_mode_i(i2c_mode),
		.addr_strap_bit0_i(1'b1), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op),
		.cmd_dev_addr_i(cmd_dev), .cmd_ptr_i(cmd_ptr), .cmd_data_i(cmd_data),
		.cmd_ready_o(cmd_ready), .done_o(done), .rdata_o(rdata));
	dcp_dev i_dcp_dev (.ref_clk_i(clk), .srst_i(srst), .lnk(lnk), .addr_strap_bit1_i(1'b0),
		.general_output_two_i(1'b1), .general_output_two_val_i(1'b1),
		.general_output_two_o(gen_out2), .general_output_two_oe_o(gen_out2_oe),
		.err_event_i(err_event), .reg_rdata_i(reg_rdata), .reg_ptr_o(reg_ptr),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .acc_addr_o(acc_addr),
		.reg_wdata_o(reg_wdata), .err_status_o(err_status), .spi_mode_o(spi_mode));
	dcp_link_props #(.I2C_LOW(I2C_LOW)) i_dcp_link_props (.ref_clk_i(clk), .srst_i(srst),
		.host_bit_clock(lnk.host_bit_clock), .addr0_or_select_pin(lnk.addr0_or_select_pin),
		.host_serial_in(lnk.host_serial_in), .dev_sdo_o(lnk.dev_sdo_o),
		.dev_sdo_oe(lnk.dev_sdo_oe), .sda(lnk.sda), .sda_dev_oe(lnk.sda_dev_oe));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (reg_wr === 1'b1) begin
			wr_cnt++;
		end
		if (reg_rd === 1'b1) begin
			rd_cnt++;
		end
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end
	task automatic send(input dcp_op_t op, input logic [6:0] dev, input logic [6:0] ptr,
		input logic [7:0] data);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmd_op = op;
		cmd_dev = dev;
		cmd_ptr = ptr;
		cmd_data = data;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// a transfer that never ends counts against the run
		if (n == 3000) begin
			err_count++;
		end
	endtask
	// mode is re-chosen after every reset, so a reset switches the link
	task automatic do_reset(input logic mode);
		@(posedge clk);
		#1 srst = 1'b1;
		i2c_mode = mode;
		repeat (5) @(posedge clk);
		#1;
		check({1'b0, reg_ptr}, 8'h00, "pointer in reset");
		check({7'h00, gen_out2_oe}, 8'h00, "strap pin released in reset");
		srst = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		check({7'h00, spi_mode}, 8'h00, "mode after reset");
		check({6'h00, gen_out2_oe, gen_out2}, 8'h03, "strap pin driven after reset");
	endtask
	task automatic t_spi_write();
		int w;
		w = wr_cnt;
		send(DCP_OP_WRITE, SPI_DEV_ADDR, 7'h7f, 8'h55);
		check({7'h00, spi_mode}, 8'h01, "spi selected");
		check({1'b0, acc_addr}, 8'h7f, "write address");
		check(reg_wdata, 8'h55, "write data");
		check({1'b0, reg_ptr}, 8'h00, "pointer wrap");
		send(DCP_OP_WRITE, SPI_DEV_ADDR, 7'h20, 8'ha3);
		check(reg_wdata, 8'ha3, "second write data");
		check({1'b0, reg_ptr}, 8'h21, "pointer step");
		check(8'(wr_cnt - w), 8'h02, "write pulses");
	endtask
	task automatic t_spi_read();
		int w;
		int r;
		w = wr_cnt;
		r = rd_cnt;
		send(DCP_OP_WRITE, 7'h11, 7'h05, 8'h99);
		check({1'b0, reg_ptr}, 8'h21, "pointer after foreign address");
		send(DCP_OP_SETPTR, SPI_DEV_ADDR, 7'h30, 8'h00);
		check({1'b0, reg_ptr}, 8'h30, "pointer set");
		check(8'(wr_cnt - w), 8'h00, "no write pulses");
		send(DCP_OP_READ, SPI_DEV_ADDR, 7'h00, 8'h00);
		check(rdata, {1'b1, ~7'h30}, "read data");
		check({1'b0, reg_ptr}, 8'h31, "pointer after read");
		check({1'b0, acc_addr}, 8'h30, "read address");
		check(8'(rd_cnt - r), 8'h01, "read pulses");
	endtask
	task automatic t_err_sticky();
		@(posedge clk);
		#1 err_event = 7'h05;
		@(posedge clk);
		#1 err_event = 7'h00;
		repeat (20) @(posedge clk);
		#1;
		check({1'b0, err_status}, 8'h05, "sticky errors");
		send(DCP_OP_SETPTR, SPI_DEV_ADDR, ERR_REG_ADDR, 8'h00);
		send(DCP_OP_READ, SPI_DEV_ADDR, 7'h00, 8'h00);
		check(rdata, 8'h05, "error register read");
		check({1'b0, err_status}, 8'h00, "errors cleared by read");
	endtask
	task automatic t_i2c();
		int w;
		int r;
		do_reset(1'b1);
		w = wr_cnt;
		send(DCP_OP_WRITE, {I2C_ADDR_HI, 3'h4}, 7'h22, 8'h66);
		check(8'(wr_cnt - w), 8'h00, "foreign i2c address");
		send(DCP_OP_WRITE, {I2C_ADDR_HI, I2C_LOW}, 7'h40, 8'h3c);
		check({1'b0, acc_addr}, 8'h40, "i2c write address");
		check(reg_wdata, 8'h3c, "i2c write data");
		check({1'b0, reg_ptr}, 8'h41, "i2c pointer step");
		send(DCP_OP_SETPTR, {I2C_ADDR_HI, I2C_LOW}, 7'h50, 8'h00);
		r = rd_cnt;
		send(DCP_OP_READ, {I2C_ADDR_HI, I2C_LOW}, 7'h00, 8'h00);
		check(rdata, {1'b1, ~7'h50}, "i2c read data");
		check({1'b0, reg_ptr}, 8'h51, "i2c pointer after read");
		check(8'(rd_cnt - r), 8'h01, "i2c read pulses");
		check({7'h00, spi_mode}, 8'h00, "i2c mode kept");
	endtask
	initial begin
		do_reset(1'b0);
		t_spi_write();
		t_spi_read();
		t_err_sticky();
		t_i2c();
		conclude();
	end
endmodule
`default_nettype wire
